// File: hdl/txi_pkg.sv
// ----------------------------------------------------------------------
// Notes on behaviour
// - raise queue empty cause when ring head becomes equal to ring tail.
// - set write-back cause when a descriptor with report status is written back.
// - report status plus delay enable write-back loads countdown from delay interval.
// - countdown expiry sets the same write-back cause; no separate delayed bit.
// - delayed interrupt is gated by the write-back cause mask bit.
// - with external phy, any change of phy link input sets link change cause.
// - in serdes mode, changes of loss of sync set link change cause.
// - serdes with autoneg: zero base page or software link reset/autoneg write signals.
// - ring low cause when tail minus head minus prefetched reaches low threshold.
// - prefetched count subtracted is clamped to at most eight descriptors.
// - start transmitting only once the whole packet sits in the transmit fifo.
// - buffers on any byte boundary; length limited only by maximum packet size.
// - three descriptor formats: legacy, data and context.
// - with extension bit set, the type field selects the descriptor format.
// - extension bit 29 clear means legacy format.
// - context descriptor moves no data and loads its control word internally.
// - null address moves no data; report status still writes the done flag.
// ----------------------------------------------------------------------
package txi_pkg;
  localparam int CAUSE_W = 4;
  localparam int QE_BIT = 0;
  localparam int WB_BIT = 1;
  localparam int LC_BIT = 2;
  localparam int LOW_BIT = 3;
  // word indices on the register bus
  localparam logic [2:0] REG_CAUSE = 3'h0;
  localparam logic [2:0] REG_MASK = 3'h1;
  localparam logic [2:0] REG_DELAY = 3'h2;
  localparam logic [2:0] REG_DCTL = 3'h3;
  localparam logic [2:0] REG_LINK = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  localparam int SERDES_BIT = 0;
  localparam int HWAN_BIT = 1;
  localparam int LINK_RESET_BIT = 2;
  localparam int ANEN_BIT = 3;
  localparam int LINK_W = 4;
  localparam int ST_PHY = 0;
  localparam int ST_SYNC = 1;
  localparam int ST_CNT = 2;
  localparam int ST_AVAIL_LSB = 16;
  localparam int DELAY_W = 16;
  localparam int EXT_BIT = 29;
  localparam int REPORT_BIT = 27;
  localparam int DELAY_EN_BIT = 31;
  localparam int TYPE_LSB = 20;
  localparam int TYPE_W = 4;
  localparam int LEN_W = 16;
  localparam logic [3:0] TYPE_CONTEXT = 4'h0;
  localparam logic [3:0] TYPE_DATA = 4'h1;
  localparam int PREFETCH_MAX = 8;
  localparam int MAX_PACKET_BYTES = 9014;
  localparam logic [31:0] RST_WORD = 32'h0;
  typedef enum logic [3:0] {
    TXI_LEGACY = 4'b0001,
    TXI_DATA = 4'b0010,
    TXI_CONTEXT = 4'b0100,
    TXI_UNKNOWN = 4'b1000
  } txi_kind_type;
  typedef struct packed {
    logic valid;
    logic report_status;
    logic delay_enable;
  } txi_wb_type;
  typedef struct packed {
    logic valid;
    txi_kind_type kind;
    logic move_data;
    logic load_context;
    logic write_done;
    logic length_bad;
  } txi_desc_type;
endpackage

// File: hdl/txi_core.sv
`timescale 1ns/1ps
module txi_core #(
  parameter int PTR_W = 16,
  parameter int PRE_W = 4,
  parameter int MAX_PACKET = txi_pkg::MAX_PACKET_BYTES
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // register bus
  input wire logic [2:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // descriptor ring state
  input wire logic [PTR_W-1:0] RING_HEAD,
  input wire logic [PTR_W-1:0] RING_TAIL,
  input wire logic [PTR_W-1:0] RING_SIZE,
  input wire logic [PRE_W-1:0] PREFETCHED,
  // descriptor write-back
  input wire txi_pkg::txi_wb_type WRITE_BACK,
  // link
  input wire logic PHY_LINK,
  input wire logic LOSS_OF_SYNC,
  input wire logic CONFIG_ZERO_PAGE,
  // descriptor decode
  input wire logic DESC_VALID,
  input wire logic [63:0] DESC_ADDR,
  input wire logic [31:0] DESC_UPPER,
  output txi_pkg::txi_desc_type DESC_RESULT,
  output logic [31:0] CONTEXT_INFO,
  // transmit start
  input wire logic TX_REQUEST,
  input wire logic PACKET_FETCHED,
  output logic TX_START,
  // interrupt
  output logic IRQ
);

  if (PTR_W < 2 || PTR_W > 16) begin : g_chk_ptr
    $error("PTR_W must lie between 2 and 16");
  end
  if (PRE_W < 4 || MAX_PACKET < 1 || MAX_PACKET > 65535) begin : g_chk_len
    $error("PRE_W below 4 or MAX_PACKET outside the length field");
  end

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return (old & ~m) | (wd & m);
  endfunction

  function automatic txi_pkg::txi_kind_type decode_kind(input logic [31:0] up);
    logic [txi_pkg::TYPE_W-1:0] t;
    t = up[txi_pkg::TYPE_LSB +: txi_pkg::TYPE_W];
    if (!up[txi_pkg::EXT_BIT]) begin
      return txi_pkg::TXI_LEGACY;
    end
    if (t == txi_pkg::TYPE_CONTEXT) begin
      return txi_pkg::TXI_CONTEXT;
    end
    if (t == txi_pkg::TYPE_DATA) begin
      return txi_pkg::TXI_DATA;
    end
    return txi_pkg::TXI_UNKNOWN;
  endfunction

  // tail is only advanced once descriptors are stored, so tail - head is trustworthy
  function automatic logic [PTR_W:0] avail_count(input logic [PTR_W-1:0] head,
      input logic [PTR_W-1:0] tail, input logic [PTR_W-1:0] size,
      input logic [PRE_W-1:0] pre);
    logic [PTR_W:0] diff;
    logic [PTR_W:0] used;
    if (tail >= head) begin
      diff = {1'b0, tail} - {1'b0, head};
    end else begin
      diff = {1'b0, tail} + {1'b0, size} - {1'b0, head};
    end
    used = (pre > PRE_W'(txi_pkg::PREFETCH_MAX)) ? (PTR_W+1)'(txi_pkg::PREFETCH_MAX) :
           (PTR_W+1)'(pre);
    return (diff > used) ? diff - used : '0;
  endfunction

  // ----------------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------------
  logic wr_accept;
  localparam int CAUSE_W_L = txi_pkg::CAUSE_W;
  logic [31:0] wd_cause;
  logic [CAUSE_W_L-1:0] cause;
  logic [CAUSE_W_L-1:0] mask;
  logic [txi_pkg::DELAY_W-1:0] delay_interval_field;
  logic [PTR_W-1:0] low_threshold_field;
  logic [txi_pkg::LINK_W-1:0] link_ctl;
  logic [txi_pkg::DELAY_W-1:0] countdown;
  logic [PTR_W:0] avail;
  logic [31:0] rd_value;

  // one wait cycle per request keeps read data a plain register
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
    end
  end

  assign wr_accept = AVS_WRITE && !AVS_WAITREQUEST;
  assign wd_cause = wr_merge(32'h0, AVS_WRITEDATA, AVS_BYTEENABLE);

  always_comb begin
    rd_value = '0;
    unique case (AVS_ADDRESS)
      txi_pkg::REG_CAUSE: rd_value[CAUSE_W_L-1:0] = cause;
      txi_pkg::REG_MASK: rd_value[CAUSE_W_L-1:0] = mask;
      txi_pkg::REG_DELAY: rd_value[txi_pkg::DELAY_W-1:0] = delay_interval_field;
      txi_pkg::REG_DCTL: rd_value[PTR_W-1:0] = low_threshold_field;
      txi_pkg::REG_LINK: rd_value[txi_pkg::LINK_W-1:0] = link_ctl;
      txi_pkg::REG_STATUS: begin
        rd_value[txi_pkg::ST_PHY] = PHY_LINK;
        rd_value[txi_pkg::ST_SYNC] = LOSS_OF_SYNC;
        rd_value[txi_pkg::ST_CNT] = (countdown != '0);
        rd_value[txi_pkg::ST_AVAIL_LSB +: PTR_W] = avail[PTR_W-1:0];
      end
      default: rd_value = '0;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      AVS_READDATA <= txi_pkg::RST_WORD;
    end else if (AVS_READ && AVS_WAITREQUEST) begin
      AVS_READDATA <= rd_value;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      delay_interval_field <= '0;
      low_threshold_field <= '0;
      link_ctl <= '0;
    end else if (wr_accept) begin
      unique case (AVS_ADDRESS)
        txi_pkg::REG_DELAY: delay_interval_field <= txi_pkg::DELAY_W'(
          wr_merge(32'(delay_interval_field), AVS_WRITEDATA, AVS_BYTEENABLE));
        txi_pkg::REG_DCTL: low_threshold_field <= PTR_W'(
          wr_merge(32'(low_threshold_field), AVS_WRITEDATA, AVS_BYTEENABLE));
        txi_pkg::REG_LINK: link_ctl <= txi_pkg::LINK_W'(
          wr_merge(32'(link_ctl), AVS_WRITEDATA, AVS_BYTEENABLE));
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------------
  logic armed;
  logic qe_prev;
  logic phy_prev;
  logic sync_prev;
  logic qe_event;
  logic link_event;
  logic low_event;
  logic sw_an;
  logic cnt_load;
  logic cnt_expire;
  logic wb_now;

  // previous-value flops only become trusted one cycle after release
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      armed <= 1'b0;
      qe_prev <= 1'b1;
      phy_prev <= 1'b0;
      sync_prev <= 1'b0;
      avail <= '0;
    end else begin
      armed <= 1'b1;
      qe_prev <= (RING_HEAD == RING_TAIL);
      phy_prev <= PHY_LINK;
      sync_prev <= LOSS_OF_SYNC;
      avail <= avail_count(RING_HEAD, RING_TAIL, RING_SIZE, PREFETCHED);
    end
  end

  assign qe_event = armed && (RING_HEAD == RING_TAIL) && !qe_prev;
  assign low_event = armed && (avail_count(RING_HEAD, RING_TAIL, RING_SIZE, PREFETCHED) ==
                     {1'b0, low_threshold_field}) && (avail != {1'b0, low_threshold_field});
  assign sw_an = wr_accept && (AVS_ADDRESS == txi_pkg::REG_LINK) &&
                 (wd_cause[txi_pkg::LINK_RESET_BIT] || wd_cause[txi_pkg::ANEN_BIT]);

  always_comb begin
    if (link_ctl[txi_pkg::SERDES_BIT]) begin
      link_event = armed && (LOSS_OF_SYNC != sync_prev);
      if (link_ctl[txi_pkg::HWAN_BIT] && (CONFIG_ZERO_PAGE || sw_an)) begin
        link_event = 1'b1;
      end
    end else begin
      link_event = armed && (PHY_LINK != phy_prev);
    end
  end

  // ----------------------------------------------------------------------
  // write-back and delayed interrupt countdown
  // ----------------------------------------------------------------------
  // a zero interval cannot count, so it falls back to an immediate cause
  assign cnt_load = WRITE_BACK.valid && WRITE_BACK.report_status && WRITE_BACK.delay_enable;
  assign wb_now = WRITE_BACK.valid && WRITE_BACK.report_status &&
                  (!WRITE_BACK.delay_enable || delay_interval_field == '0);
  assign cnt_expire = (countdown == txi_pkg::DELAY_W'(1)) && !cnt_load;

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      countdown <= '0;
    end else if (cnt_load) begin
      countdown <= delay_interval_field;
    end else if (countdown != '0) begin
      countdown <= countdown - txi_pkg::DELAY_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // cause, mask and interrupt
  // ----------------------------------------------------------------------
  logic [CAUSE_W_L-1:0] cause_set;
  logic [CAUSE_W_L-1:0] cause_clr;
  logic [CAUSE_W_L-1:0] next_cause;
  logic [CAUSE_W_L-1:0] next_mask;

  always_comb begin
    cause_set = '0;
    cause_set[txi_pkg::QE_BIT] = qe_event;
    cause_set[txi_pkg::WB_BIT] = wb_now || cnt_expire;
    cause_set[txi_pkg::LC_BIT] = link_event;
    cause_set[txi_pkg::LOW_BIT] = low_event;
    cause_clr = '0;
    if (wr_accept && AVS_ADDRESS == txi_pkg::REG_CAUSE) begin
      cause_clr = wd_cause[CAUSE_W_L-1:0];
    end
    next_cause = (cause & ~cause_clr) | cause_set;
    next_mask = mask;
    if (wr_accept && AVS_ADDRESS == txi_pkg::REG_MASK) begin
      next_mask = CAUSE_W_L'(wr_merge(32'(mask), AVS_WRITEDATA, AVS_BYTEENABLE));
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      cause <= '0;
      mask <= '0;
    end else begin
      cause <= next_cause;
      mask <= next_mask;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(next_cause & next_mask);
    end
  end

  // ----------------------------------------------------------------------
  // descriptor decode
  // ----------------------------------------------------------------------
  txi_pkg::txi_kind_type kind;
  logic len_bad;
  logic addr_null;

  assign kind = decode_kind(DESC_UPPER);
  assign addr_null = (DESC_ADDR == 64'h0);
  // any start address is fine; only the length is bounded
  assign len_bad = (kind != txi_pkg::TXI_CONTEXT) &&
                   (DESC_UPPER[txi_pkg::LEN_W-1:0] > txi_pkg::LEN_W'(MAX_PACKET));

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      DESC_RESULT <= '{valid: 1'b0, kind: txi_pkg::TXI_LEGACY, default: 1'b0};
    end else begin
      DESC_RESULT.valid <= DESC_VALID;
      DESC_RESULT.kind <= kind;
      DESC_RESULT.move_data <= DESC_VALID && !addr_null && !len_bad &&
        (kind == txi_pkg::TXI_LEGACY || kind == txi_pkg::TXI_DATA);
      DESC_RESULT.load_context <= DESC_VALID && (kind == txi_pkg::TXI_CONTEXT);
      DESC_RESULT.write_done <= DESC_VALID && DESC_UPPER[txi_pkg::REPORT_BIT];
      DESC_RESULT.length_bad <= DESC_VALID && len_bad;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      CONTEXT_INFO <= txi_pkg::RST_WORD;
    end else if (DESC_VALID && kind == txi_pkg::TXI_CONTEXT) begin
      CONTEXT_INFO <= DESC_UPPER;
    end
  end

  // ----------------------------------------------------------------------
  // transmit start
  // ----------------------------------------------------------------------
  // waiting for the full packet costs latency but allows checksum insertion
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      TX_START <= 1'b0;
    end else begin
      TX_START <= TX_REQUEST && PACKET_FETCHED;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  AST_QUEUE_EMPTY: assert property (
    armed && $rose(RING_HEAD == RING_TAIL) |=> cause[txi_pkg::QE_BIT])
    else $error("queue empty cause not set");
  AST_WB_IMMEDIATE: assert property (
    WRITE_BACK.valid && WRITE_BACK.report_status && !WRITE_BACK.delay_enable
    |=> cause[txi_pkg::WB_BIT])
    else $error("write-back cause not set");
  AST_CNT_LOAD: assert property (
    cnt_load |=> countdown == $past(delay_interval_field))
    else $error("countdown not loaded from interval");
  AST_CNT_EXPIRE: assert property (
    countdown == txi_pkg::DELAY_W'(1) && !cnt_load |=> countdown == '0 &&
    cause[txi_pkg::WB_BIT])
    else $error("countdown expiry did not set write-back cause");
  AST_WB_MASKED: assert property (
    cause[txi_pkg::WB_BIT] && mask[txi_pkg::WB_BIT] |-> IRQ)
    else $error("unmasked write-back cause without interrupt");
  AST_PHY_LINK: assert property (
    armed && !link_ctl[txi_pkg::SERDES_BIT] && $changed(PHY_LINK)
    |=> cause[txi_pkg::LC_BIT])
    else $error("phy link change missed");
  AST_LOS_LINK: assert property (
    armed && link_ctl[txi_pkg::SERDES_BIT] && $changed(LOSS_OF_SYNC)
    |=> cause[txi_pkg::LC_BIT])
    else $error("loss of sync change missed");
  // any prefetch count above the limit must give the same figure as the limit itself
  AST_PREFETCH_CLAMP: assert property (
    armed && PREFETCHED > PRE_W'(txi_pkg::PREFETCH_MAX) |=>
    avail == $past(avail_count(RING_HEAD, RING_TAIL, RING_SIZE,
    PRE_W'(txi_pkg::PREFETCH_MAX))))
    else $error("prefetch count not clamped");
  AST_TX_START: assert property (
    TX_START |-> $past(PACKET_FETCHED) && $past(TX_REQUEST))
    else $error("transmit started before packet fetched");
  AST_LEGACY: assert property (
    DESC_VALID && !DESC_UPPER[txi_pkg::EXT_BIT] |=>
    DESC_RESULT.kind == txi_pkg::TXI_LEGACY)
    else $error("legacy descriptor misdecoded");
  AST_CONTEXT: assert property (
    DESC_VALID && kind == txi_pkg::TXI_CONTEXT |=>
    !DESC_RESULT.move_data && DESC_RESULT.load_context && CONTEXT_INFO == $past(DESC_UPPER))
    else $error("context descriptor handled wrongly");
  AST_NULL_ADDR: assert property (
    DESC_VALID && addr_null && DESC_UPPER[txi_pkg::REPORT_BIT] |=>
    DESC_RESULT.write_done && !DESC_RESULT.move_data)
    else $error("null address descriptor handled wrongly");
  AST_STICKY: assert property (
    cause[txi_pkg::LC_BIT] && !(wr_accept && AVS_ADDRESS == txi_pkg::REG_CAUSE)
    |=> cause[txi_pkg::LC_BIT])
    else $error("cause bit dropped without a clear");
  AST_ONE_WAIT: assert property (
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");

  COV_DELAYED: cover property (cnt_load ##[1:20] cnt_expire);
  COV_LINK: cover property (link_event && link_ctl[txi_pkg::SERDES_BIT]);
  COV_CONTEXT: cover property (DESC_RESULT.load_context);
  COV_LOW: cover property (low_event ##1 IRQ);

endmodule

// File: verification/txi_host_model.sv
`timescale 1ns/1ps
// ----
// host driver and descriptor memory
// ----
module txi_host_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // software side: store, then commit, then fetch
  input wire logic store,
  input wire logic [95:0] store_desc,
  input wire logic commit,
  input wire logic fetch,
  // ring and descriptor side
  output logic [15:0] head,
  output logic [15:0] tail,
  output logic desc_valid,
  output logic [95:0] desc
);
  logic [95:0] mem [16];
  logic [3:0] wp;

  // the tail only ever moves over entries already written to memory
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wp <= 4'h0;
      tail <= 16'h0;
    end else begin
      if (store) begin
        mem[wp] <= store_desc;
        wp <= wp + 4'h1;
      end
      if (commit) tail <= {12'h0, wp};
    end
  end

  // released descriptor lines flip so a stale value is never mistaken
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      head <= 16'h0;
      desc_valid <= 1'b0;
      desc <= 96'h0;
    end else begin
      desc_valid <= fetch;
      if (fetch) begin
        desc <= mem[head[3:0]];
        head <= {12'h0, head[3:0] + 4'h1};
      end else desc <= ~desc;
    end
  end
endmodule

// File: verification/txi_core_tb_top.sv
`timescale 1ns/1ps
module txi_core_tb_top;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rd;
  logic wait_req, irq, txstart, dvalid, store = 1'b0, commit = 1'b0, fetch = 1'b0;
  logic [15:0] head, tail;
  logic [3:0] pre = 4'h0;
  txi_pkg::txi_wb_type wb = '0;
  logic phy = 1'b0, sync_loss = 1'b0, zpage = 1'b0, txreq = 1'b0, fetched = 1'b0;
  logic [95:0] desc, sdesc = 96'h0;
  txi_pkg::txi_desc_type res;
  logic [31:0] ctx, seed;
  logic [31:0] du [6];
  logic [63:0] da [6];
  int fails = 0;
  int cmp_count = 0;

  always #12.5 clock = ~clock;

  txi_core txi_core_i (.CLOCK(clock), .RESET_N(reset_n), .AVS_ADDRESS(addr),
    .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .RING_HEAD(head), .RING_TAIL(tail),
    .RING_SIZE(16'h10), .PREFETCHED(pre), .WRITE_BACK(wb), .PHY_LINK(phy),
    .LOSS_OF_SYNC(sync_loss), .CONFIG_ZERO_PAGE(zpage), .DESC_VALID(dvalid),
    .DESC_ADDR(desc[95:32]), .DESC_UPPER(desc[31:0]), .DESC_RESULT(res),
    .CONTEXT_INFO(ctx), .TX_REQUEST(txreq), .PACKET_FETCHED(fetched), .TX_START(txstart),
    .IRQ(irq));

  txi_host_model txi_host_model_i (.clock(clock), .reset_n(reset_n), .store(store),
    .store_desc(sdesc), .commit(commit), .fetch(fetch), .head(head), .tail(tail),
    .desc_valid(dvalid), .desc(desc));

  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] mk(input logic e, input logic [3:0] t, input logic r,
                                     input logic [15:0] n);
    return {2'b00, e, 1'b0, r, 3'b000, t, 4'h0, n};
  endfunction

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // request held until waitrequest is sampled low, released after that edge
  // a slave that never answers is left to the watchdog
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    wr_en <= w;
    rd_en <= !w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clock);
    end while (wait_req !== 1'b0);
    rd = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rchk(input string n, input logic [2:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask

  task automatic clr;
    bus(1'b1, txi_pkg::REG_CAUSE, 32'hf);
  endtask

  task automatic put(input logic [31:0] u, input logic [63:0] a);
    store <= 1'b1;
    sdesc <= {a, u};
    @(posedge clock);
  endtask

  task automatic hand_over;
    store <= 1'b0;
    commit <= 1'b1;
    @(posedge clock);
    commit <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic dcheck(input logic [31:0] u, input logic [63:0] a);
    txi_pkg::txi_kind_type k;
    logic mv;
    logic lb;
    k = !u[29] ? txi_pkg::TXI_LEGACY : u[23:20] == txi_pkg::TYPE_DATA ? txi_pkg::TXI_DATA :
        u[23:20] == txi_pkg::TYPE_CONTEXT ? txi_pkg::TXI_CONTEXT : txi_pkg::TXI_UNKNOWN;
    lb = k != txi_pkg::TXI_CONTEXT && 32'(u[15:0]) > txi_pkg::MAX_PACKET_BYTES;
    mv = (k == txi_pkg::TXI_LEGACY || k == txi_pkg::TXI_DATA) && a != 64'h0 && !lb;
    fetch <= 1'b1;
    @(posedge clock);
    fetch <= 1'b0;
    repeat (2) @(posedge clock);
    chk("desc", 32'(res), 32'({1'b1, k, mv, k == txi_pkg::TXI_CONTEXT, u[27], lb}));
    if (k == txi_pkg::TXI_CONTEXT) chk("context", ctx, u);
  endtask

  task automatic lchk;
    repeat (3) @(posedge clock);
    rchk("link", txi_pkg::REG_CAUSE, 32'h4);
    clr;
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 8; i++) rchk("reset", 3'(i), 32'h0);
    seed = 32'hb457;
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      case (i)
        0: du[i] = mk(1'b0, seed[23:20], 1'b1, {3'h0, seed[12:0]});
        1: du[i] = mk(1'b1, 4'h1, seed[0], {3'h0, seed[12:0]});
        2: du[i] = mk(1'b1, 4'h0, 1'b0, seed[15:0]);
        3: du[i] = mk(1'b1, 4'h5, 1'b1, 16'h10);
        4: du[i] = mk(1'b0, 4'h0, 1'b1, 16'h40);
        default: du[i] = mk(1'b0, 4'h0, 1'b0, 16'h2337);
      endcase
      da[i] = (i == 4) ? 64'h0 : {seed, 32'h1};
      put(du[i], da[i]);
    end
    hand_over();
    for (int i = 0; i < 6; i++) dcheck(du[i], da[i]);
    rchk("cause", txi_pkg::REG_CAUSE, 32'h9);
    clr;
    // more than eight prefetched must count as eight
    bus(1'b1, txi_pkg::REG_DCTL, 32'h3);
    pre <= 4'hc;
    for (int i = 0; i < 11; i++) put(32'h0, 64'h0);
    hand_over();
    rchk("avail", txi_pkg::REG_STATUS, 32'h0003_0000);
    rchk("cause", txi_pkg::REG_CAUSE, 32'h8);
    bus(1'b1, txi_pkg::REG_MASK, 32'h8);
    chk("irq", 32'(irq), 32'h1);
    clr;
    chk("irq", 32'(irq), 32'h0);
    pre <= 4'h0;
    for (int i = 0; i < 11; i++) dcheck(32'h0, 64'h0);
    rchk("cause", txi_pkg::REG_CAUSE, 32'h9);
    clr;
    bus(1'b1, txi_pkg::REG_MASK, 32'h0);
    wb <= '{1'b1, 1'b0, 1'b0};
    @(posedge clock);
    wb <= '{1'b1, 1'b1, 1'b0};
    @(posedge clock);
    wb <= '0;
    repeat (3) @(posedge clock);
    rchk("cause", txi_pkg::REG_CAUSE, 32'h2);
    chk("irq", 32'(irq), 32'h0);
    bus(1'b1, txi_pkg::REG_MASK, 32'h2);
    chk("irq", 32'(irq), 32'h1);
    clr;
    bus(1'b1, txi_pkg::REG_DELAY, 32'h6);
    wb <= '{1'b1, 1'b1, 1'b1};
    @(posedge clock);
    wb <= '0;
    repeat (3) @(posedge clock);
    chk("irq", 32'(irq), 32'h0);
    repeat (3) @(posedge clock);
    chk("irq", 32'(irq), 32'h0);
    repeat (2) @(posedge clock);
    chk("irq", 32'(irq), 32'h1);
    rchk("cause", txi_pkg::REG_CAUSE, 32'h2);
    bus(1'b1, txi_pkg::REG_MASK, 32'h0);
    chk("irq", 32'(irq), 32'h0);
    clr;
    phy <= 1'b1;
    lchk();
    bus(1'b1, txi_pkg::REG_LINK, 32'h1);
    sync_loss <= 1'b1;
    lchk();
    bus(1'b1, txi_pkg::REG_LINK, 32'h3);
    zpage <= 1'b1;
    @(posedge clock);
    zpage <= 1'b0;
    lchk();
    bus(1'b1, txi_pkg::REG_LINK, 32'h7);
    lchk();
    bus(1'b1, txi_pkg::REG_LINK, 32'hb);
    lchk();
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      bus(1'b1, txi_pkg::REG_MASK, seed);
      rchk("mask", txi_pkg::REG_MASK, {28'h0, seed[3:0]});
    end
    txreq <= 1'b1;
    repeat (3) @(posedge clock);
    chk("start", 32'(txstart), 32'h0);
    fetched <= 1'b1;
    repeat (2) @(posedge clock);
    chk("start", 32'(txstart), 32'h1);
    stop_test();
  end

  // the whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    stop_test();
  end
endmodule
